// *** rtl/pcac_top.sv ***
// Access control, counting enables and overflow interrupt for the
// performance counters. Assumes the core presents one decoded
// coprocessor move per cp_valid pulse and waits for ack or undef.
`timescale 1ns/10ps
module pcac_top
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        cp_valid,
    input  wire logic        cp_write,
    input  wire logic [2:0]  cp_opc1,
    input  wire logic [3:0]  cp_crn,
    input  wire logic [3:0]  cp_crm,
    input  wire logic [2:0]  cp_opc2,
    input  wire logic [31:0] cp_wdata,
    input  wire logic        priv_mode,
    input  wire logic        secure_state,
    input  wire logic [1:0]  counter_sel,
    input  wire logic        ctrl_bit5,
    input  wire logic        invasive_debug_permit,
    input  wire logic        noninvasive_debug_permit,
    input  wire logic        secure_invasive_debug_permit,
    input  wire logic        secure_noninvasive_debug_permit,
    input  wire logic        secure_user_noninvasive_permit,
    input  wire logic [3:0]  event_hit,
    input  wire logic        cycle_wrap,
    input  wire logic [4:0]  ovf_clr,
    output logic             cp_ack,
    output logic             cp_undef,
    output logic      [31:0] cp_rdata,
    output logic             event_count_en,
    output logic             cycle_count_en,
    output logic             monitor_irq_out_n
);
    // ===========================================================
    // Decode
    logic        is_c9;
    logic        hit_cnt;
    logic        hit_usr;
    logic        hit_ien;
    logic        user_en_r;
    logic        user_en_nxt;
    logic [4:0]  ien_r;
    logic [4:0]  ien_nxt;
    logic [4:0]  ovf_r;
    logic [4:0]  ovf_nxt;
    logic [4:0]  wrap_all;
    logic [3:0]  ctr_wrap;
    logic [31:0] bank_rdata;
    logic        ack_nxt;
    logic        undef_nxt;
    logic        rd_ctr_nxt;
    logic        rd_ctr_r;
    logic [31:0] rdata_nxt;
    logic [31:0] rdata_r;
    logic        ctr_wr;
    logic        ev_en;
    logic        cyc_en;
    logic        irq_n_nxt;
    logic        irq_n_r;

    localparam int IEN_MSB = pcac_pkg::NUM_CTR - 1;

    assign is_c9   = cp_valid && (cp_opc1 == pcac_pkg::CP_OPC1)
                     && (cp_crn == pcac_pkg::CP_CRN);
    assign hit_cnt = is_c9 && (cp_crm == pcac_pkg::CRM_CNT)
                     && (cp_opc2 == pcac_pkg::OPC2_CNT);
    assign hit_usr = is_c9 && (cp_crm == pcac_pkg::CRM_CTL)
                     && (cp_opc2 == pcac_pkg::OPC2_USR);
    assign hit_ien = is_c9 && (cp_crm == pcac_pkg::CRM_CTL)
                     && (cp_opc2 == pcac_pkg::OPC2_IEN);

    // ===========================================================
    // Access permission and response
    // Security state plays no part here: one shared copy for both
    always_comb
    begin
        ack_nxt    = 1'b0;
        undef_nxt  = 1'b0;
        rd_ctr_nxt = 1'b0;
        ctr_wr     = 1'b0;
        rdata_nxt  = 32'h0000_0000;
        if (hit_cnt)
        begin
            if (priv_mode || user_en_r)
            begin
                ack_nxt    = 1'b1;
                ctr_wr     = cp_write;
                rd_ctr_nxt = !cp_write;
            end
            else
                undef_nxt  = 1'b1;
        end
        else if (hit_usr)
        begin
            if (cp_write && !priv_mode)
                undef_nxt = 1'b1;
            else
            begin
                ack_nxt = 1'b1;
                rdata_nxt[pcac_pkg::USR_EN_BIT] = user_en_r;
            end
        end
        else if (hit_ien)
        begin
            // User enable deliberately not consulted here
            if (!priv_mode)
                undef_nxt = 1'b1;
            else
            begin
                ack_nxt = 1'b1;
                rdata_nxt[IEN_MSB:0] = ien_r[IEN_MSB:0];
                rdata_nxt[pcac_pkg::IEN_CYC_B] =
                    ien_r[pcac_pkg::IEN_CYC_I];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cp_ack   <= 1'b0;
            cp_undef <= 1'b0;
            rd_ctr_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
        end
        else
        begin
            cp_ack   <= ack_nxt;
            cp_undef <= undef_nxt;
            rd_ctr_r <= rd_ctr_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // Both sources are flops; the mux only picks the valid one
    assign cp_rdata = rd_ctr_r ? bank_rdata : rdata_r;

    // ===========================================================
    // Control registers
    always_comb
    begin
        user_en_nxt = user_en_r;
        ien_nxt     = ien_r;
        if (hit_usr && cp_write && priv_mode)
            user_en_nxt = cp_wdata[pcac_pkg::USR_EN_BIT];
        if (hit_ien && cp_write && priv_mode)
        begin
            // Ones set, zeros leave the bit alone
            ien_nxt[IEN_MSB:0] = ien_r[IEN_MSB:0]
                | cp_wdata[IEN_MSB:0];
            ien_nxt[pcac_pkg::IEN_CYC_I] = ien_r[pcac_pkg::IEN_CYC_I]
                | cp_wdata[pcac_pkg::IEN_CYC_B];
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            user_en_r <= pcac_pkg::USR_EN_RST;
            ien_r     <= pcac_pkg::IEN_RST;
        end
        else
        begin
            user_en_r <= user_en_nxt;
            ien_r     <= ien_nxt;
        end
    end

    // ===========================================================
    // Counting enables
    always_comb
    begin
        ev_en  = 1'b0;
        cyc_en = !ctrl_bit5;
        if (!(invasive_debug_permit || noninvasive_debug_permit))
        begin
            ev_en  = 1'b0;
            cyc_en = !ctrl_bit5;
        end
        else if (!secure_state)
        begin
            ev_en  = 1'b1;
            cyc_en = 1'b1;
        end
        else if (secure_invasive_debug_permit
                 || secure_noninvasive_debug_permit)
        begin
            ev_en  = 1'b1;
            cyc_en = 1'b1;
        end
        else if (priv_mode)
        begin
            ev_en  = 1'b0;
            cyc_en = !ctrl_bit5;
        end
        else if (secure_user_noninvasive_permit)
        begin
            ev_en  = 1'b1;
            cyc_en = 1'b1;
        end
        else
        begin
            ev_en  = 1'b0;
            cyc_en = !ctrl_bit5;
        end
    end

    assign event_count_en = ev_en;
    assign cycle_count_en = cyc_en;

    pcac_ctr_bank u_bank
    (
        .core_clk (core_clk),
        .rst      (rst),
        .cnt_inc  (event_hit & {pcac_pkg::NUM_CTR{ev_en}}),
        .wr_en    (ctr_wr),
        .wr_idx   (counter_sel),
        .wr_data  (cp_wdata),
        .rd_idx   (counter_sel),
        .rd_data  (bank_rdata),
        .wrap     (ctr_wrap)
    );

    // ===========================================================
    // Overflow interrupt
    assign wrap_all = {cycle_wrap, ctr_wrap};

    always_comb
    begin
        // A wrap in the clearing cycle keeps its flag
        ovf_nxt   = (ovf_r & ~ovf_clr) | wrap_all;
        irq_n_nxt = !(|(ovf_nxt & ien_nxt));
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ovf_r   <= pcac_pkg::OVF_RST;
            irq_n_r <= 1'b1;
        end
        else
        begin
            ovf_r   <= ovf_nxt;
            irq_n_r <= irq_n_nxt;
        end
    end

    assign monitor_irq_out_n = irq_n_r;

    // ===========================================================
    // Assertions
    property p_cnt_undef;
        @(posedge core_clk) disable iff (rst)
        hit_cnt && !priv_mode && !user_en_r |=> cp_undef && !cp_ack;
    endproperty
    a_cnt_undef: assert property (p_cnt_undef)
        else $error("user counter access not refused");

    property p_cnt_user_ok;
        @(posedge core_clk) disable iff (rst)
        hit_cnt && !priv_mode && user_en_r |=> cp_ack && !cp_undef;
    endproperty
    a_cnt_user_ok: assert property (p_cnt_user_ok)
        else $error("enabled user counter access refused");

    property p_usr_wr_user;
        @(posedge core_clk) disable iff (rst)
        hit_usr && cp_write && !priv_mode
        |=> cp_undef && $stable(user_en_r);
    endproperty
    a_usr_wr_user: assert property (p_usr_wr_user)
        else $error("user write to user enable accepted");

    property p_ien_user;
        @(posedge core_clk) disable iff (rst)
        hit_ien && !priv_mode |=> cp_undef ##0 $stable(ien_r);
    endproperty
    a_ien_user: assert property (p_ien_user)
        else $error("user access to interrupt enables accepted");

    property p_ien_no_clear;
        @(posedge core_clk) disable iff (rst)
        ##1 (($past(ien_r) & ~ien_r) == 5'h00);
    endproperty
    a_ien_no_clear: assert property (p_ien_no_clear)
        else $error("interrupt enable cleared by set register");

    property p_usr_read;
        @(posedge core_clk) disable iff (rst)
        hit_usr && !cp_write
        |=> cp_ack && (cp_rdata[31:1] == 31'h0000_0000)
            && (cp_rdata[0] == $past(user_en_r));
    endproperty
    a_usr_read: assert property (p_usr_read)
        else $error("user enable read value wrong");

    property p_no_debug;
        @(posedge core_clk) disable iff (rst)
        !(invasive_debug_permit || noninvasive_debug_permit)
        |-> !event_count_en && (cycle_count_en == !ctrl_bit5);
    endproperty
    a_no_debug: assert property (p_no_debug)
        else $error("counting without debug permission");

    property p_nonsecure;
        @(posedge core_clk) disable iff (rst)
        (invasive_debug_permit || noninvasive_debug_permit)
        && !secure_state |-> event_count_en && cycle_count_en;
    endproperty
    a_nonsecure: assert property (p_nonsecure)
        else $error("non-secure counting not enabled");

    property p_irq;
        @(posedge core_clk) disable iff (rst)
        (|(ovf_r & ien_r)) |-> !monitor_irq_out_n;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled overflow without interrupt");

    c_user_cnt: cover property (@(posedge core_clk) disable iff (rst)
        hit_cnt && !priv_mode && user_en_r ##1 cp_ack);
    c_undef: cover property (@(posedge core_clk) disable iff (rst)
        hit_ien && !priv_mode ##1 cp_undef);
    c_irq: cover property (@(posedge core_clk) disable iff (rst)
        $fell(monitor_irq_out_n));
endmodule // pcac_top

// *** rtl/pcac_pkg.sv ***
// Constants for the performance counter access and enable control block.
// Assumes one core clock; the surrounding core decodes coprocessor moves.
//
// Functional notes
// - Four independent 32-bit event counters
// - Selection register picks accessed counter
// - Privileged access both states, one copy
// - User counter access only when enable set
// - User counter access otherwise raises undefined
// - Counters at opc1 0, c9, c13, 2
// - No debug permit: events stop, cycle per bit5
// - Debug permit, non-secure: everything counts
// - Secure privileged, no secure permit: events stop
// - Secure user, no secure permit: secure-user permit decides counting
// - User enable bit zero, upper bits zero
// - User enable: read anywhere, privileged write
// - User enable never opens interrupt enables
// - User enable at opc1 0, c9, c14, 0
// - Cycle enable bit 31, events bits 3:0
// - Set register writes ones, ignores zeros
// - Set register reads current enable states
// - Set register privileged only, else undefined
// - Set register at opc1 0, c9, c14, 1
// - Enabled counter overflow raises interrupt
// - Interrupt only on active-low output pin
package pcac_pkg;
    // ===========================================================
    // Sizes
    localparam int          NUM_CTR    = 4;
    localparam int          CTR_W      = 32;
    localparam int          IDX_W      = 2;
    localparam int          IEN_W      = NUM_CTR + 1;
    // ===========================================================
    // Coprocessor encodings
    localparam logic [2:0]  CP_OPC1    = 3'h0;
    localparam logic [3:0]  CP_CRN     = 4'h9;
    localparam logic [3:0]  CRM_CNT    = 4'hd;
    localparam logic [2:0]  OPC2_CNT   = 3'h2;
    localparam logic [3:0]  CRM_CTL    = 4'he;
    localparam logic [2:0]  OPC2_USR   = 3'h0;
    localparam logic [2:0]  OPC2_IEN   = 3'h1;
    // ===========================================================
    // Field layout and reset values
    localparam int          USR_EN_BIT = 0;
    localparam int          IEN_CYC_B  = 31;
    localparam int          IEN_CYC_I  = NUM_CTR;
    localparam logic        USR_EN_RST = 1'b0;
    localparam logic [4:0]  IEN_RST    = 5'h00;
    localparam logic [4:0]  OVF_RST    = 5'h00;
    localparam logic [31:0] CTR_RST    = 32'h0000_0000;
    localparam logic [31:0] CTR_MAX    = 32'hffff_ffff;
endpackage

// *** rtl/pcac_ctr_bank.sv ***
// Bank of four event counters with one write port and a registered
// read port. Assumes increments are already gated by the enable logic.
`timescale 1ns/10ps
module pcac_ctr_bank
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  cnt_inc,
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_idx,
    input  wire logic [31:0] wr_data,
    input  wire logic [1:0]  rd_idx,
    output logic      [31:0] rd_data,
    output logic      [3:0]  wrap
);
    logic [31:0] cnt_r   [pcac_pkg::NUM_CTR];
    logic [31:0] cnt_nxt [pcac_pkg::NUM_CTR];
    logic [31:0] rd_nxt;

    // ===========================================================
    // Counters
    for (genvar i = 0; i < pcac_pkg::NUM_CTR; i++)
    begin : g_ctr
        logic hit;
        assign hit = wr_en && (wr_idx == 2'(i));
        // Software write beats a same-cycle event on that counter
        assign wrap[i] = !hit && cnt_inc[i]
                         && (cnt_r[i] == pcac_pkg::CTR_MAX);
        always_comb
        begin
            cnt_nxt[i] = cnt_r[i];
            if (hit)
                cnt_nxt[i] = wr_data;
            else if (cnt_inc[i])
                cnt_nxt[i] = cnt_r[i] + 32'h0000_0001;
        end
        always_ff @(posedge core_clk or posedge rst)
        begin
            if (rst)
                cnt_r[i] <= pcac_pkg::CTR_RST;
            else
                cnt_r[i] <= cnt_nxt[i];
        end
    end

    // ===========================================================
    // Read port
    always_comb
    begin
        rd_nxt = cnt_r[rd_idx];
    end
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rd_data <= pcac_pkg::CTR_RST;
        else
            rd_data <= rd_nxt;
    end
endmodule // pcac_ctr_bank

// *** tb/pcac_top_tb.sv ***
// Self-checking bench for the performance counter access block.
// Assumes pcac_pkg and the rtl files are compiled ahead of it.
`timescale 1ns/10ps
module pcac_top_tb;
    // ==========================================================
    // Signals
    logic        core_clk, rst, cp_valid, cp_write, priv_mode;
    logic        secure_state, ctrl_bit5, cycle_wrap;
    logic        cp_ack, cp_undef, event_count_en, cycle_count_en;
    logic        monitor_irq_out_n;
    logic [2:0]  cp_opc1, cp_opc2;
    logic [3:0]  cp_crn, cp_crm, event_hit;
    logic [4:0]  perm, ovf_clr;
    logic [1:0]  counter_sel;
    logic [31:0] cp_wdata, cp_rdata;
    int          fails, checks, cyc;

    pcac_top pcac_top_i
    (
        .core_clk                        (core_clk),
        .rst                             (rst),
        .cp_valid                        (cp_valid),
        .cp_write                        (cp_write),
        .cp_opc1                         (cp_opc1),
        .cp_crn                          (cp_crn),
        .cp_crm                          (cp_crm),
        .cp_opc2                         (cp_opc2),
        .cp_wdata                        (cp_wdata),
        .priv_mode                       (priv_mode),
        .secure_state                    (secure_state),
        .counter_sel                     (counter_sel),
        .ctrl_bit5                       (ctrl_bit5),
        .invasive_debug_permit           (perm[0]),
        .noninvasive_debug_permit        (perm[1]),
        .secure_invasive_debug_permit    (perm[2]),
        .secure_noninvasive_debug_permit (perm[3]),
        .secure_user_noninvasive_permit  (perm[4]),
        .event_hit                       (event_hit),
        .cycle_wrap                      (cycle_wrap),
        .ovf_clr                         (ovf_clr),
        .cp_ack                          (cp_ack),
        .cp_undef                        (cp_undef),
        .cp_rdata                        (cp_rdata),
        .event_count_en                  (event_count_en),
        .cycle_count_en                  (cycle_count_en),
        .monitor_irq_out_n               (monitor_irq_out_n)
    );

    // ==========================================================
    // Clock and hang guard
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Whole run is well under 2000 cycles
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fails++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic tally_and_finish();
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    // One move; rsp is {ack, undef} expected one cycle later
    task automatic acc(input logic wr, input logic [3:0] crm,
                       input logic [2:0] op2, input logic [31:0] wd,
                       input logic pv, input logic [1:0] rsp,
                       input logic [31:0] rd);
        @(negedge core_clk);
        cp_valid  <= 1'b1;
        cp_write  <= wr;
        cp_crm    <= crm;
        cp_opc2   <= op2;
        cp_wdata  <= wd;
        priv_mode <= pv;
        @(negedge core_clk);
        cp_valid <= 1'b0;
        chk("ack_undef", 32'(rsp), 32'({cp_ack, cp_undef}));
        if (rsp == 2'b10 && !wr)
            chk("cp_rdata", rd, cp_rdata);
    endtask

    task automatic ctr(input logic wr, input logic [1:0] sel,
                       input logic [31:0] wd, input logic pv,
                       input logic [1:0] rsp, input logic [31:0] rd);
        counter_sel = sel;
        acc(wr, pcac_pkg::CRM_CNT, pcac_pkg::OPC2_CNT, wd, pv, rsp, rd);
    endtask

    task automatic ctl(input logic wr, input logic [2:0] op2,
                       input logic [31:0] wd, input logic pv,
                       input logic [1:0] rsp, input logic [31:0] rd);
        acc(wr, pcac_pkg::CRM_CTL, op2, wd, pv, rsp, rd);
    endtask

    // One-cycle pulse on the event side, then irq level is checked
    task automatic pulse(input logic [3:0] h, input logic cw,
                         input logic [4:0] oc, input logic irq_n);
        @(negedge core_clk);
        event_hit  <= h;
        cycle_wrap <= cw;
        ovf_clr    <= oc;
        @(negedge core_clk);
        event_hit  <= 4'h0;
        cycle_wrap <= 1'b0;
        ovf_clr    <= 5'h00;
        @(negedge core_clk);
        chk("monitor_irq_out_n", 32'(irq_n), 32'(monitor_irq_out_n));
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        ctl(0, pcac_pkg::OPC2_USR, 0, 1, 2'b10, 32'h0);
        ctl(0, pcac_pkg::OPC2_IEN, 0, 1, 2'b10, 32'h0);
        chk("irq_idle", 32'h1, 32'(monitor_irq_out_n));
    endtask

    // Write in one security state, read back in the other
    task automatic t_counters();
        for (int i = 0; i < 4; i++)
        begin
            secure_state = i[0];
            ctr(1, i[1:0], 32'h8765_4321 ^ (32'h1111_1111 * i), 1,
                2'b10, 0);
        end
        for (int i = 0; i < 4; i++)
        begin
            secure_state = ~i[0];
            ctr(0, i[1:0], 0, 1, 2'b10,
                32'h8765_4321 ^ (32'h1111_1111 * i));
        end
    endtask

    task automatic t_user();
        ctr(0, 0, 0, 0, 2'b01, 0);
        ctr(1, 0, 32'h0, 0, 2'b01, 0);
        ctr(0, 0, 0, 1, 2'b10, 32'h8765_4321);
        ctl(1, pcac_pkg::OPC2_USR, 1, 0, 2'b01, 0);
        ctl(0, pcac_pkg::OPC2_USR, 0, 0, 2'b10, 32'h0);
        ctl(1, pcac_pkg::OPC2_USR, '1, 1, 2'b10, 0);
        ctl(0, pcac_pkg::OPC2_USR, 0, 0, 2'b10, 32'h1);
        ctr(1, 2, 32'hdead_beef, 0, 2'b10, 0);
        ctr(0, 2, 0, 0, 2'b10, 32'hdead_beef);
        ctl(0, pcac_pkg::OPC2_IEN, 0, 0, 2'b01, 0);
        ctl(1, pcac_pkg::OPC2_IEN, '1, 0, 2'b01, 0);
        ctl(0, pcac_pkg::OPC2_IEN, 0, 1, 2'b10, 32'h0);
        ctl(1, pcac_pkg::OPC2_USR, 0, 1, 2'b10, 0);
        ctl(1, 3'h3, '1, 1, 2'b00, 0);
        // Foreign primary register, first opcode and secondary register
        cp_crn = 4'h8;
        ctl(0, pcac_pkg::OPC2_USR, 0, 1, 2'b00, 0);
        cp_crn  = pcac_pkg::CP_CRN;
        cp_opc1 = 3'h1;
        ctr(0, 0, 0, 1, 2'b00, 0);
        cp_opc1 = pcac_pkg::CP_OPC1;
        acc(0, 4'hc, pcac_pkg::OPC2_CNT, 0, 1, 2'b00, 0);
    endtask

    // Ones set, zeros leave; bit 3 stays clear for the irq test
    task automatic t_ien();
        ctl(1, pcac_pkg::OPC2_IEN, 32'h8000_0005, 1, 2'b10, 0);
        ctl(1, pcac_pkg::OPC2_IEN, 32'h0000_0002, 1, 2'b10, 0);
        ctl(0, pcac_pkg::OPC2_IEN, 0, 1, 2'b10, 32'h8000_0007);
    endtask

    task automatic t_enables();
        logic g, s, ev, cy;
        for (int k = 0; k < 256; k++)
        begin
            @(negedge core_clk);
            {perm, secure_state, priv_mode, ctrl_bit5} = k[7:0];
            #1;
            g  = perm[0] | perm[1];
            s  = perm[2] | perm[3];
            ev = g && (!secure_state || s || (!priv_mode && perm[4]));
            cy = ev || !ctrl_bit5;
            chk("event_count_en", 32'(ev), 32'(event_count_en));
            chk("cycle_count_en", 32'(cy), 32'(cycle_count_en));
        end
        priv_mode    = 1'b1;
        secure_state = 1'b0;
    endtask                                         // above

    task automatic t_ovf();
        perm = 5'h00;
        ctr(1, 1, 32'h5, 1, 2'b10, 0);
        pulse(4'h2, 0, 0, 1);
        ctr(0, 1, 0, 1, 2'b10, 32'h5);
        perm = 5'h02;
        pulse(4'h2, 0, 0, 1);
        pulse(4'h2, 0, 0, 1);
        ctr(0, 1, 0, 1, 2'b10, 32'h7);
        ctr(1, 0, 32'hffff_ffff, 1, 2'b10, 0);
        pulse(4'h1, 0, 0, 0);
        ctr(0, 0, 0, 1, 2'b10, 32'h0);
        pulse(4'h0, 0, 5'h01, 1);
        // Flag held while disabled must raise irq once enabled
        ctr(1, 3, 32'hffff_ffff, 1, 2'b10, 0);
        pulse(4'h8, 0, 0, 1);
        ctl(1, pcac_pkg::OPC2_IEN, 32'h8, 1, 2'b10, 0);
        chk("irq_late", 32'h0, 32'(monitor_irq_out_n));
        pulse(4'h0, 0, 5'h08, 1);
        pulse(4'h0, 1, 0, 0);
        pulse(4'h0, 0, 5'h10, 1);
        // Wrap and clear in one cycle: the flag must survive
        pulse(4'h0, 1, 5'h10, 0);
        pulse(4'h0, 0, 5'h10, 1);
    endtask

    // Mid-run reset clears counters, enables and flags
    task automatic t_midreset();
        pulse(4'h0, 1, 0, 0);
        @(negedge core_clk);
        rst = 1'b1;
        @(negedge core_clk);
        chk("irq_in_reset", 32'h1, 32'(monitor_irq_out_n));
        rst = 1'b0;
        ctr(0, 1, 0, 1, 2'b10, 32'h0);
        ctr(0, 1, 0, 0, 2'b01, 0);
        ctl(0, pcac_pkg::OPC2_IEN, 0, 1, 2'b10, 32'h0);
        ctl(0, pcac_pkg::OPC2_USR, 0, 0, 2'b10, 32'h0);
        chk("irq_after_reset", 32'h1, 32'(monitor_irq_out_n));
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        {rst, cp_valid, cp_write, cycle_wrap} = 4'h8;
        {cp_crm, cp_opc2, cp_wdata, event_hit, ovf_clr} = '0;
        {secure_state, ctrl_bit5, counter_sel} = '0;
        cp_opc1   = pcac_pkg::CP_OPC1;
        cp_crn    = pcac_pkg::CP_CRN;
        priv_mode = 1'b1;
        perm      = 5'h02;
        fails     = 0;
        checks    = 0;
        cyc       = 0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_counters();
        t_user();
        t_ien();
        t_enables();
        t_ovf();
        t_midreset();
        tally_and_finish();
    end
endmodule // pcac_top_tb
